// ==== verilog/viu_cfg.svh ====
`ifndef VIU_CFG_SVH_CFG
`define VIU_CFG_SVH_CFG

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VIU_ADDR_IE       8'hA8
`define VIU_ADDR_CFG      8'hE8
`define VIU_ADDR_STAT     8'hE9
`define VIU_ADDR_MASK     8'hEA
`define VIU_ADDR_PEND     8'hEB

// ----------------------------------------------------------------
// Enable register fields
// ----------------------------------------------------------------
`define VIU_IE_EA         7
`define VIU_IE_VS         5
`define VIU_IE_RSVD_SER   4
`define VIU_IE_LOW_MSB    3
`define VIU_IE_WMASK      8'hAF
`define VIU_IE_RESET      8'h00

// ----------------------------------------------------------------
// Config register fields and reset values
// ----------------------------------------------------------------
`define VIU_CFG_VS_POL    0
`define VIU_CFG_P33_LATCH 1
`define VIU_CFG_WMASK     8'h03
`define VIU_CFG_RESET     8'h02
`define VIU_SRC_RESET     5'h00
`define VIU_SRC_ONE       5'h01
`define VIU_NSRC          5

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define VIU_VEC_RESET     16'h0000
`define VIU_VEC_EXT0      16'h0003
`define VIU_VEC_TMR0      16'h000B
`define VIU_VEC_EXT1      16'h0013
`define VIU_VEC_TMR1      16'h001B
`define VIU_VEC_VSYNC     16'h0023

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VIU_CLK_PERIOD_PS 5000
`define VIU_RST_HOLD_OSC  24
`define VIU_OSC_PER_CLK   1
`define VIU_RST_HOLD_CYC  (`VIU_RST_HOLD_OSC / `VIU_OSC_PER_CLK)
`define VIU_RST_CNT_W     5

`endif

// ==== verilog/viu_pkg.sv ====
package viu_pkg;

  // ----------------------------------------------------------------
  // Shared types
  // ----------------------------------------------------------------
  typedef logic [7:0]  viu_byte_type;
  typedef logic [15:0] viu_vec_type;
  typedef logic [4:0]  viu_src_type;

  typedef enum logic [2:0] {
    VIU_SRC_EXT0  = 3'h0,
    VIU_SRC_TMR0  = 3'h1,
    VIU_SRC_EXT1  = 3'h2,
    VIU_SRC_TMR1  = 3'h3,
    VIU_SRC_VSYNC = 3'h4
  } viu_src_idx_type;

endpackage : viu_pkg

// ==== verilog/viu_edge_det.sv ====
`timescale 1ns/1ps
module viu_edge_det #(
  parameter logic RST_LVL = 1'b1
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  input  wire logic i_both,
  input  wire logic i_act_high,
  output logic      o_edge
);
  import viu_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic s1_d;
  logic s2_d;
  logic s3_d;
  logic rise_w;
  logic fall_w;

  // ----------------------------------------------------------------
  // Synchroniser; only s2 and s3 feed the detector
  // ----------------------------------------------------------------
  always_comb begin
    s1_d = i_pin;
    s2_d = s1_q;
    s3_d = s2_q;
    rise_w = s2_q & ~s3_q;
    fall_w = ~s2_q & s3_q;
    if (i_both) begin
      o_edge = rise_w | fall_w;
    end else if (i_act_high) begin
      o_edge = rise_w;
    end else begin
      o_edge = fall_w;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q <= RST_LVL;
      s2_q <= RST_LVL;
      s3_q <= RST_LVL;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

endmodule : viu_edge_det

// ==== verilog/viu_rst_filter.sv ====
`timescale 1ns/1ps
`include "viu_cfg.svh"
module viu_rst_filter (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  output logic      o_rst
);
  import viu_pkg::*;

  localparam logic [`VIU_RST_CNT_W-1:0] HOLD = `VIU_RST_CNT_W'(`VIU_RST_HOLD_CYC);

  logic [`VIU_RST_CNT_W-1:0] cnt_q;
  logic [`VIU_RST_CNT_W-1:0] cnt_d;
  logic                      rst_q;
  logic                      rst_d;

  // ----------------------------------------------------------------
  // Pin must stay high for the whole hold time; any low restarts
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = '0;
    if (i_pin) begin
      cnt_d = (cnt_q == HOLD) ? HOLD : cnt_q + 1'b1;
    end
    rst_d = (cnt_d == HOLD);
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      rst_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rst_q <= rst_d;
    end
  end

  assign o_rst = rst_q;

  rst_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_rst) |-> ($past(cnt_q) == HOLD - 1'b1) && $past(i_pin))
    else $error("reset asserted before pin held long enough");

endmodule : viu_rst_filter

// ==== verilog/viu_top.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "viu_cfg.svh"
// Summary of operation
// - External 0 vectors to 003H, timer 0 to 00BH, external 1 to 013H.
// - Reset starts at 000H; timer 1 vectors to 01BH, vertical sync to 023H.
// - Vertical sync requests on leading edge; active polarity is programmable.
// - External interrupt 1 requests on every rising and falling transition.
// - No serial-port source, enable bit or flag exists.
// - No priority register; one enable register at A8H controls enabling.
// - Reset pin high for two machine cycles resets; driver must hold that long.
// - External interrupt 0 comes from open-drain port 3 bit 3.
module viu_top (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_rst_pin,
  input  wire logic                  i_p33_in,
  input  wire logic                  i_ext1,
  input  wire logic                  i_vsync,
  input  wire logic                  i_tmr0_ovf,
  input  wire logic                  i_tmr1_ovf,
  input  wire logic                  i_vec_ack,
  input  wire viu_pkg::viu_byte_type i_reg_addr,
  input  wire viu_pkg::viu_byte_type i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output viu_pkg::viu_byte_type      o_reg_rdata,
  output logic                       o_vec_req,
  output viu_pkg::viu_vec_type       o_vec_addr,
  output logic                       o_irq,
  output logic                       o_core_reset,
  output logic                       o_p33_out,
  output logic                       o_p33_oe_n
);
  import viu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  viu_byte_type    ie_q;
  viu_byte_type    ie_d;
  viu_byte_type    cfg_q;
  viu_byte_type    cfg_d;
  viu_src_type     stat_q;
  viu_src_type     stat_d;
  viu_src_type     mask_q;
  viu_src_type     mask_d;
  viu_src_type     pend_q;
  viu_src_type     pend_d;
  logic            req_q;
  logic            req_d;
  viu_src_idx_type sel_q;
  viu_src_idx_type sel_d;
  viu_vec_type     vec_q;
  viu_vec_type     vec_d;
  viu_byte_type    rdata_q;
  viu_byte_type    rdata_d;

  logic            sreset;
  logic            ev_ext0;
  logic            ev_ext1;
  logic            ev_vs;
  viu_src_type     ev_w;
  viu_src_type     clr_w;
  viu_src_type     w1c_w;
  viu_src_type     en_q_w;
  viu_src_type     en_d_w;
  viu_src_type     elig_w;
  viu_src_type     stat_keep_w;
  logic            wr_ie;
  logic            wr_cfg;
  logic            wr_stat;
  logic            wr_mask;

  // ----------------------------------------------------------------
  // Reset pin filter and edge detectors
  // ----------------------------------------------------------------
  viu_rst_filter u_rst_filter (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_rst_pin),
    .o_rst      (sreset)
  );

  // Port line idles high when released, so a falling edge is the request
  viu_edge_det #(.RST_LVL(1'b1)) u_edge_ext0 (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_p33_in),
    .i_both     (1'b0),
    .i_act_high (1'b0),
    .o_edge     (ev_ext0)
  );

  viu_edge_det #(.RST_LVL(1'b1)) u_edge_ext1 (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_ext1),
    .i_both     (1'b1),
    .i_act_high (1'b0),
    .o_edge     (ev_ext1)
  );

  // Leading edge is the move into the active level
  viu_edge_det #(.RST_LVL(1'b0)) u_edge_vs (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_pin      (i_vsync),
    .i_both     (1'b0),
    .i_act_high (cfg_q[`VIU_CFG_VS_POL]),
    .o_edge     (ev_vs)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_ie   = 1'b0;
    wr_cfg  = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (i_reg_wr && (i_reg_addr == `VIU_ADDR_IE)) begin
      wr_ie = 1'b1;
    end else if (i_reg_wr && (i_reg_addr == `VIU_ADDR_CFG)) begin
      wr_cfg = 1'b1;
    end else if (i_reg_wr && (i_reg_addr == `VIU_ADDR_STAT)) begin
      wr_stat = 1'b1;
    end else if (i_reg_wr && (i_reg_addr == `VIU_ADDR_MASK)) begin
      wr_mask = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sources, enables and selection
  // ----------------------------------------------------------------
  always_comb begin
    ev_w   = {ev_vs, i_tmr1_ovf, ev_ext1, i_tmr0_ovf, ev_ext0};
    w1c_w  = wr_stat ? i_reg_wdata[`VIU_NSRC-1:0] : `VIU_SRC_RESET;
    clr_w  = (i_vec_ack && req_q) ? (`VIU_SRC_ONE << sel_q) : `VIU_SRC_RESET;
    // Serial enable bit is never stored, so it cannot enable anything
    ie_d   = wr_ie ? (i_reg_wdata & `VIU_IE_WMASK) : ie_q;
    cfg_d  = wr_cfg ? (i_reg_wdata & `VIU_CFG_WMASK) : cfg_q;
    mask_d = wr_mask ? i_reg_wdata[`VIU_NSRC-1:0] : mask_q;
    // Set beats clear so an edge landing on the ack is not lost
    pend_d = ev_w | (pend_q & ~clr_w);
    stat_d = ev_w | (stat_q & ~w1c_w);
    stat_keep_w = stat_q & ~w1c_w;
    en_q_w = {ie_q[`VIU_IE_VS], ie_q[`VIU_IE_LOW_MSB:0]} & {`VIU_NSRC{ie_q[`VIU_IE_EA]}};
    en_d_w = {ie_d[`VIU_IE_VS], ie_d[`VIU_IE_LOW_MSB:0]} & {`VIU_NSRC{ie_d[`VIU_IE_EA]}};
    if (sreset) begin
      ie_d   = `VIU_IE_RESET;
      cfg_d  = `VIU_CFG_RESET;
      mask_d = `VIU_SRC_RESET;
      pend_d = `VIU_SRC_RESET;
      stat_d = `VIU_SRC_RESET;
      en_d_w = `VIU_SRC_RESET;
    end
    elig_w = pend_d & en_d_w;
  end

  // Fixed natural order; lowest source index wins
  always_comb begin
    req_d = |elig_w;
    sel_d = sel_q;
    for (int i = `VIU_NSRC - 1; i >= 0; i--) begin
      if (elig_w[i]) begin
        sel_d = viu_src_idx_type'(i[2:0]);
      end
    end
    vec_d = vec_q;
    if (sreset) begin
      vec_d = `VIU_VEC_RESET;
      sel_d = VIU_SRC_EXT0;
    end else if (req_d) begin
      case (sel_d)
        VIU_SRC_EXT0:  vec_d = `VIU_VEC_EXT0;
        VIU_SRC_TMR0:  vec_d = `VIU_VEC_TMR0;
        VIU_SRC_EXT1:  vec_d = `VIU_VEC_EXT1;
        VIU_SRC_TMR1:  vec_d = `VIU_VEC_TMR1;
        VIU_SRC_VSYNC: vec_d = `VIU_VEC_VSYNC;
        default:       vec_d = `VIU_VEC_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (i_reg_rd && (i_reg_addr == `VIU_ADDR_IE)) begin
      rdata_d = ie_q;
    end else if (i_reg_rd && (i_reg_addr == `VIU_ADDR_CFG)) begin
      rdata_d = cfg_q;
    end else if (i_reg_rd && (i_reg_addr == `VIU_ADDR_STAT)) begin
      rdata_d = {3'h0, stat_q};
    end else if (i_reg_rd && (i_reg_addr == `VIU_ADDR_MASK)) begin
      rdata_d = {3'h0, mask_q};
    end else if (i_reg_rd && (i_reg_addr == `VIU_ADDR_PEND)) begin
      rdata_d = {3'h0, pend_q};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ie_q    <= `VIU_IE_RESET;
      cfg_q   <= `VIU_CFG_RESET;
      stat_q  <= `VIU_SRC_RESET;
      mask_q  <= `VIU_SRC_RESET;
      pend_q  <= `VIU_SRC_RESET;
      req_q   <= 1'b0;
      sel_q   <= VIU_SRC_EXT0;
      vec_q   <= `VIU_VEC_RESET;
      rdata_q <= 8'h00;
    end else begin
      ie_q    <= ie_d;
      cfg_q   <= cfg_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      pend_q  <= pend_d;
      req_q   <= req_d;
      sel_q   <= sel_d;
      vec_q   <= vec_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata  = rdata_q;
  assign o_vec_req    = req_q;
  assign o_vec_addr   = vec_q;
  assign o_irq        = |(stat_q & mask_q);
  assign o_core_reset = sreset;
  // Open-drain: only ever pulls low; a written one releases the line
  assign o_p33_out    = 1'b0;
  assign o_p33_oe_n   = cfg_q[`VIU_CFG_P33_LATCH];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  vec_low_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_vec_req && (sel_q == VIU_SRC_EXT0 || sel_q == VIU_SRC_TMR0 || sel_q == VIU_SRC_EXT1)
      |-> (o_vec_addr == ((sel_q == VIU_SRC_EXT0) ? `VIU_VEC_EXT0 :
                          (sel_q == VIU_SRC_TMR0) ? `VIU_VEC_TMR0 : `VIU_VEC_EXT1)))
    else $error("wrong vector for low sources");

  vec_high_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_vec_req && (sel_q == VIU_SRC_TMR1 || sel_q == VIU_SRC_VSYNC)
      |-> (o_vec_addr == ((sel_q == VIU_SRC_TMR1) ? `VIU_VEC_TMR1 : `VIU_VEC_VSYNC)))
    else $error("wrong vector for high sources");

  reset_vec_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $fell(o_core_reset) |-> (o_vec_addr == `VIU_VEC_RESET) && !o_vec_req)
    else $error("reset vector not presented");

  vs_lead_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cfg_q[`VIU_CFG_VS_POL] ? $rose(i_vsync) : $fell(i_vsync)) && $stable(cfg_q) && !o_core_reset
      |-> ##[2:3] (pend_q[VIU_SRC_VSYNC] || i_vec_ack || o_core_reset))
    else $error("vertical sync leading edge missed");

  ext1_both_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $changed(i_ext1) && !o_core_reset |-> ##[2:3] (pend_q[VIU_SRC_EXT1] || i_vec_ack || o_core_reset))
    else $error("external one transition missed");

  no_serial_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_reg_rd && (i_reg_addr == `VIU_ADDR_IE) |=> !o_reg_rdata[`VIU_IE_RSVD_SER])
    else $error("serial enable bit reads back");

  glob_off_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !ie_q[`VIU_IE_EA] && !wr_ie |=> !o_vec_req)
    else $error("request with global enable off");

  ext0_fall_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $fell(i_p33_in) && !o_core_reset |-> ##[2:3] (pend_q[VIU_SRC_EXT0] || i_vec_ack || o_core_reset))
    else $error("port line falling edge missed");

  ack_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_vec_ack && o_vec_req && ((ev_w & clr_w) == `VIU_SRC_RESET)
      |=> ((pend_q & $past(clr_w)) == `VIU_SRC_RESET))
    else $error("acknowledged request still pending");

  req_enabled_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_vec_req |-> ((pend_q & en_q_w) != `VIU_SRC_RESET) && (pend_q[sel_q] && en_q_w[sel_q]))
    else $error("request without enabled pending source");

  stat_sticky_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !o_core_reset |=> ((stat_q & $past(stat_keep_w)) == $past(stat_keep_w)))
    else $error("status bit lost without clear");

endmodule : viu_top

// ==== sim/viu_core_model.sv ====
`timescale 1ns/1ps
module viu_core_model (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_vec_req,
  input  wire viu_pkg::viu_vec_type i_vec_addr,
  input  wire logic [3:0]           i_ack_delay,
  input  wire logic                 i_p33_out,
  input  wire logic                 i_p33_oe_n,
  input  wire logic                 i_pull_low,
  output logic                      o_vec_ack,
  output logic                      o_p33_wire,
  output int                        o_ack_cnt,
  output viu_pkg::viu_vec_type      o_last_vec
);
  import viu_pkg::*;

  logic [3:0] wait_q;

  // ----------------------------------------------------------------
  // Open-drain line with pull-up
  // ----------------------------------------------------------------
  // Any low driver wins; otherwise the pull-up holds the line high
  assign o_p33_wire = ((!i_p33_oe_n && !i_p33_out) || i_pull_low) ? 1'b0 : 1'b1;

  // ----------------------------------------------------------------
  // Vector fetch acknowledge
  // ----------------------------------------------------------------
  // Ack waits i_ack_delay cycles so slow cores can be mimicked
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_vec_ack  <= 1'b0;
      wait_q     <= 4'h0;
      o_ack_cnt  <= 0;
      o_last_vec <= 16'h0000;
    end else if (o_vec_ack) begin
      o_vec_ack <= 1'b0;
      wait_q    <= 4'h0;
      if (i_vec_req) begin
        o_ack_cnt  <= o_ack_cnt + 1;
        o_last_vec <= i_vec_addr;
      end
    end else if (i_vec_req) begin
      if (wait_q >= i_ack_delay) begin
        o_vec_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule : viu_core_model

// ==== sim/vectored_interrupt_unit_tb_top.sv ====
`timescale 1ns/1ps
`include "viu_cfg.svh"
module vectored_interrupt_unit_tb_top;
  import viu_pkg::*;

  logic         clk, rst_n, rst_pin, ext1, vsync, t0, t1, wr, rd, pull_low, ack, p33_wire;
  logic         vec_req, irq, core_rst, p33_out, p33_oe_n;
  logic [3:0]   ack_delay;
  viu_byte_type addr, wdata, rdata, d;
  viu_vec_type  vec_addr, last_vec;
  int           ack_cnt, b, n_fail, samples_checked;

  localparam int          STEP_K   [10] = '{0, 1, 3, 3, 4, 4, 5, 5, 5, 5};
  localparam bit          STEP_V   [10] = '{0, 0, 1, 0, 0, 1, 1, 0, 1, 0};
  localparam logic [15:0] STEP_VEC [10] = '{16'h000B, 16'h001B, 16'h0003, 16'h0000, 16'h0013,
                                            16'h0013, 16'h0000, 16'h0023, 16'h0023, 16'h0000};

  viu_top dut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_rst_pin(rst_pin), .i_p33_in(p33_wire), .i_ext1(ext1),
    .i_vsync(vsync), .i_tmr0_ovf(t0), .i_tmr1_ovf(t1), .i_vec_ack(ack), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_vec_req(vec_req),
    .o_vec_addr(vec_addr), .o_irq(irq), .o_core_reset(core_rst), .o_p33_out(p33_out),
    .o_p33_oe_n(p33_oe_n)
  );

  viu_core_model core (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_vec_req(vec_req), .i_vec_addr(vec_addr),
    .i_ack_delay(ack_delay), .i_p33_out(p33_out), .i_p33_oe_n(p33_oe_n), .i_pull_low(pull_low),
    .o_vec_ack(ack), .o_p33_wire(p33_wire), .o_ack_cnt(ack_cnt), .o_last_vec(last_vec)
  );

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run is a few hundred cycles; this span of 20000 cycles is far beyond it
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input viu_byte_type got, input viu_byte_type exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out

  task automatic reg_wr(input viu_byte_type a, input viu_byte_type v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input viu_byte_type a, output viu_byte_type v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_rd

  // Events: 0 timer0, 1 timer1, 2 both timers, 3 pull line low, 4 ext1 level, 5 vsync level
  task automatic ev(input int k, input bit v);
    b = ack_cnt;
    @(posedge clk);
    case (k)
      0: t0 <= 1'b1;
      1: t1 <= 1'b1;
      2: begin
        t0 <= 1'b1;
        t1 <= 1'b1;
      end
      3: pull_low <= v;
      4: ext1 <= v;
      default: vsync <= v;
    endcase
    @(posedge clk);
    t0 <= 1'b0;
    t1 <= 1'b0;
  endtask : ev

  // Zero expected vector means no fetch may happen
  task automatic settle(input logic [15:0] exp);
    int n;
    for (n = 0; n < 30 && ack_cnt == b; n++) begin
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    #1;
    chk_out(16'(ack_cnt - b), {15'h0000, exp != 16'h0000});
    if (exp != 16'h0000) begin
      chk_out(last_vec, exp);
    end
  endtask : settle

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    rst_pin = 1'b0;
    ext1 = 1'b1;
    vsync = 1'b0;
    t0 = 1'b0;
    t1 = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pull_low = 1'b0;
    ack_delay = 4'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_out({15'h0000, p33_oe_n}, 16'h0001);
    chk_out(vec_addr, 16'h0000);
    reg_rd(8'hA8, d);
    chk_reg(d, 8'h00);
    reg_rd(`VIU_ADDR_CFG, d);
    chk_reg(d, `VIU_CFG_RESET);
    reg_wr(8'hA8, 8'hFF);
    reg_rd(8'hA8, d);
    chk_reg(d, 8'hAF);
    reg_wr(8'h10, 8'hFF);
    reg_rd(8'h10, d);
    chk_reg(d, 8'h00);
    // Each source and edge kind, vsync polarity flipped before the last two steps
    for (int i = 0; i < 10; i++) begin
      if (i == 8) begin
        reg_wr(`VIU_ADDR_CFG, 8'h03);
      end
      ev(STEP_K[i], STEP_V[i]);
      settle(STEP_VEC[i]);
    end
    // Two sources at once with a slow core: lowest index first
    ack_delay <= 4'h6;
    ev(2, 1'b0);
    settle(16'h000B);
    b = ack_cnt;
    settle(16'h001B);
    // Source held off by a cleared global enable stays pending and still raises the status line
    ack_delay <= 4'h0;
    reg_wr(8'hA8, 8'h2F);
    reg_wr(`VIU_ADDR_STAT, 8'h1F);
    reg_wr(`VIU_ADDR_MASK, 8'h02);
    ev(0, 1'b0);
    settle(16'h0000);
    chk_out({15'h0000, irq}, 16'h0001);
    reg_rd(`VIU_ADDR_PEND, d);
    chk_reg(d, 8'h02);
    reg_rd(`VIU_ADDR_MASK, d);
    chk_reg(d, 8'h02);
    reg_rd(`VIU_ADDR_STAT, d);
    chk_reg(d, 8'h02);
    reg_wr(`VIU_ADDR_STAT, 8'h02);
    reg_rd(`VIU_ADDR_STAT, d);
    chk_reg(d, 8'h00);
    chk_out({15'h0000, irq}, 16'h0000);
    b = ack_cnt;
    reg_wr(8'hA8, 8'hAF);
    settle(16'h000B);
    reg_rd(`VIU_ADDR_PEND, d);
    chk_reg(d, 8'h00);
    // Reset pin one cycle short of the hold time must not reset
    @(posedge clk);
    rst_pin <= 1'b1;
    repeat (23) @(posedge clk);
    rst_pin <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_out({15'h0000, core_rst}, 16'h0000);
    reg_rd(8'hA8, d);
    chk_reg(d, 8'hAF);
    // Full hold time resets and returns the vector to the start address
    @(posedge clk);
    rst_pin <= 1'b1;
    repeat (23) @(posedge clk);
    #1;
    chk_out({15'h0000, core_rst}, 16'h0000);
    @(posedge clk);
    #1;
    chk_out({15'h0000, core_rst}, 16'h0001);
    // Vector register follows the registered core reset one cycle later
    @(posedge clk);
    rst_pin <= 1'b0;
    #1;
    chk_out(vec_addr, 16'h0000);
    chk_out({15'h0000, core_rst}, 16'h0001);
    repeat (3) @(posedge clk);
    reg_rd(8'hA8, d);
    chk_reg(d, 8'h00);
    stop_test();
  end
endmodule : vectored_interrupt_unit_tb_top
